// >>> design/interrupt_priority_map.v
`timescale 1ns/1ps
`default_nettype none
`include "irq_map.vh"

// Behaviour
// - Nine hardware levels; non-maskable level outranks every maskable one.
// - Maskable levels 0..7 by fixed priority, 0 highest, 7 lowest.
// - Level 0 is driven by timer channel 0 output, the time-of-day tick.
// - Level 3 carries the serial port request.
// - Level 4 carries the internal modem request.
// - Level 5 carries the video vertical retrace request.
// - Level 6 carries the diskette adapter request.
// - Three levels are taken from the expansion channel for adapters.
// - Non-maskable request pulses once for every keyboard scan code.
// - One master controller handles all maskable levels, no cascading.
// - Acknowledged levels 0..7 return type codes hex 8 through hex f.
module interrupt_priority_map (
    input wire clock_i,
    input wire rst_n_i,
    input wire timer0_out_i,
    input wire serial_irq_i,
    input wire modem_irq_i,
    input wire retrace_irq_i,
    input wire diskette_irq_i,
    input wire [2:0] chan_irq_i,
    input wire scan_code_i,
    input wire [7:0] mask_i,
    input wire inta_i,
    input wire eoi_i,
    output reg int_o,
    output reg [7:0] vector_o,
    output reg vector_valid_o,
    output reg nmi_o,
    output reg [7:0] in_service_o
);
    // One request: pin edge, two sync flops, edge pulse, pending bit, then
    // int_o a cycle later if the level is unmasked and above what is served.
    // The core answers with a one-cycle acknowledge; the code follows a cycle
    // later, the pending bit moves to in-service and int_o drops for a cycle.
    // An end-of-interrupt pulse retires the highest level in service.
    // Acknowledge, end-of-interrupt and mask come from logic on this clock,
    // so they are used directly, without synchronising flops.

    // Per-level request path
    wire [7:0] raw_lvl;
    wire [7:0] edge_lvl;
    wire scan_edge;
    // Pending and in-service state with their next values
    reg [7:0] pend_q;
    reg [7:0] pend_d;
    reg [7:0] isr_d;
    reg [7:0] ack_sel;
    reg [7:0] eoi_sel;
    // Priority resolution
    reg req_any;
    reg [2:0] req_lvl;
    reg isr_any;
    reg [2:0] isr_lvl;
    reg [2:0] ack_lvl;
    reg [7:0] above_mask;
    wire [7:0] elig;
    // Loop indices, one per process so neither has two drivers
    integer i;
    integer j;

    // Source to level wiring; levels 1, 2 and 7 come in from the expansion
    // channel, so adapters there are as asynchronous as the on-board pins
    assign raw_lvl[`LVL_TIMER] = timer0_out_i;
    assign raw_lvl[`LVL_SERIAL] = serial_irq_i;
    assign raw_lvl[`LVL_MODEM] = modem_irq_i;
    assign raw_lvl[`LVL_RETRACE] = retrace_irq_i;
    assign raw_lvl[`LVL_DISKETTE] = diskette_irq_i;
    assign raw_lvl[`LVL_CHAN_A] = chan_irq_i[0];
    assign raw_lvl[`LVL_CHAN_B] = chan_irq_i[1];
    assign raw_lvl[`LVL_CHAN_C] = chan_irq_i[2];

    // Edge-triggered capture; sources are asynchronous pins. A line left high
    // asks only once, so a source sharing a level must drop and pulse again.
    genvar g;
    generate
        for (g = 0; g < `IRQ_LEVELS; g = g + 1) begin : gen_lvl
            edge_sync_detect #(
                .ACTIVE_HIGH(1)
            ) u_lvl (
                .clock_i(clock_i),
                .rst_n_i(rst_n_i),
                .async_i(raw_lvl[g]),
                .rise_o(edge_lvl[g])
            );
        end
    endgenerate

    // Keyboard scan-code strobe feeds the non-maskable path
    edge_sync_detect #(
        .ACTIVE_HIGH(1)
    ) u_scan (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .async_i(scan_code_i),
        .rise_o(scan_edge)
    );

    // Highest in-service level, scanning from the lowest priority up
    always @* begin
        isr_any = 1'b0;
        isr_lvl = 3'h0;
        for (i = `IRQ_LEVELS - 1; i >= 0; i = i - 1) begin
            if (in_service_o[i]) begin
                isr_any = 1'b1;
                isr_lvl = i[2:0];
            end
        end
    end

    // Only levels strictly above the one being served may break in
    always @* begin
        // Nothing in service: every level may ask
        above_mask = 8'hff;
        if (isr_any) begin
            case (isr_lvl)
                3'h0: above_mask = 8'h00;
                3'h1: above_mask = 8'h01;
                3'h2: above_mask = 8'h03;
                3'h3: above_mask = 8'h07;
                3'h4: above_mask = 8'h0f;
                3'h5: above_mask = 8'h1f;
                3'h6: above_mask = 8'h3f;
                3'h7: above_mask = 8'h7f;
                default: above_mask = 8'h00;
            endcase
        end
    end

    // Masked levels stay pending without raising a request; a level in
    // service also blocks itself until it is retired
    assign elig = pend_q & ~mask_i & above_mask;

    // Pick the top eligible level, scanning from the lowest priority up
    always @* begin
        req_any = 1'b0;
        req_lvl = 3'h0;
        for (j = `IRQ_LEVELS - 1; j >= 0; j = j - 1) begin
            if (elig[j]) begin
                req_any = 1'b1;
                req_lvl = j[2:0];
            end
        end
    end

    // Acknowledge and end-of-interrupt decode
    always @* begin
        // Nothing eligible at the ack: report the lowest level, set nothing
        ack_lvl = req_any ? req_lvl : `LVL_SPURIOUS;
        ack_sel = 8'h00;
        eoi_sel = 8'h00;
        if (inta_i && req_any) begin
            ack_sel[req_lvl] = 1'b1;
        end
        if (eoi_i && isr_any) begin
            eoi_sel[isr_lvl] = 1'b1;
        end
    end

    // Next pending and in-service words
    always @* begin
        // A new edge in the ack cycle survives: set wins over clear
        pend_d = (pend_q & ~ack_sel) | edge_lvl;
        // Done before the ack set so an eoi cannot wipe a fresh grant
        isr_d = (in_service_o & ~eoi_sel) | ack_sel;
    end

    // Pending latch; one master controller, no cascade, all levels local
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            pend_q <= `PEND_RESET;
        end else begin
            pend_q <= pend_d;
        end
    end

    // In-service bits hold off equal and lower levels until retired
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            in_service_o <= `PEND_RESET;
        end else begin
            in_service_o <= isr_d;
        end
    end

    // Dropped during the ack so the core does not take the same level twice;
    // it comes back one cycle later if another level is eligible
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            int_o <= 1'b0;
        end else begin
            int_o <= req_any & ~inta_i;
        end
    end

    // Type code follows the ack by one cycle and then holds for the core
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            vector_valid_o <= 1'b0;
            vector_o <= `VEC_RESET;
        end else begin
            vector_valid_o <= inta_i;
            if (inta_i) begin
                vector_o <= `VEC_BASE | {5'h00, ack_lvl};
            end
        end
    end

    // Never masked, never queued behind the maskable levels
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            nmi_o <= 1'b0;
        end else begin
            nmi_o <= scan_edge;
        end
    end
endmodule // interrupt_priority_map

`default_nettype wire

// >>> inc/irq_map.vh
`ifndef IRQ_MAP_VH
`define IRQ_MAP_VH

// Maskable levels handled by the single controller
`define IRQ_LEVELS 8
// Level assignment of the on-board and expansion channel sources
`define LVL_TIMER 3'h0
`define LVL_CHAN_A 3'h1
`define LVL_CHAN_B 3'h2
`define LVL_SERIAL 3'h3
`define LVL_MODEM 3'h4
`define LVL_RETRACE 3'h5
`define LVL_DISKETTE 3'h6
`define LVL_CHAN_C 3'h7
// Type code handed out for level 0; levels 0..7 give 8..f
`define VEC_BASE 8'h08
// Level reported when an acknowledge finds nothing pending
`define LVL_SPURIOUS 3'h7
// Reset values
`define PEND_RESET 8'h00
`define VEC_RESET 8'h00

`endif

// >>> design/edge_sync_detect.v
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser plus rising-edge detector for one request line
module edge_sync_detect #(
    parameter ACTIVE_HIGH = 1
) (
    input wire clock_i,
    input wire rst_n_i,
    input wire async_i,
    output reg rise_o
);
    // Idle level of the pin; the chain resets to it so no edge follows reset
    localparam IDLE = (ACTIVE_HIGH != 0) ? 1'b0 : 1'b1;

    reg meta_q;
    reg sync_q;
    reg prev_q;
    wire rise_d;

    // Polarity applied behind the second flop; the raw pin feeds meta_q only
    assign rise_d = (ACTIVE_HIGH != 0) ? (sync_q & ~prev_q) : (prev_q & ~sync_q);

    // meta_q only feeds sync_q; edge logic looks at the stable copies
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            meta_q <= IDLE;
            sync_q <= IDLE;
            prev_q <= IDLE;
            rise_o <= 1'b0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
            rise_o <= rise_d;
        end
    end
endmodule // edge_sync_detect

`default_nettype wire

// >>> verif/ipm_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// Core side: acks after a lag, retires services one by one
module ipm_core_model (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic int_o,
    input wire logic vector_valid_o,
    input wire logic [1:0] lag_i,
    output logic inta_i,
    output logic eoi_i
);
    logic [2:0] hold_q;
    logic [2:0] cnt_q;
    logic [3:0] open_q;
    logic fire;
    assign fire = open_q != 4'h0 && cnt_q == 3'h0;
    // Slow retirement lets services nest; inta_i guard stops a double ack
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            {hold_q, cnt_q, open_q, inta_i, eoi_i} <= 12'h000;
        end else begin
            hold_q <= int_o ? hold_q + 3'h1 : 3'h0;
            inta_i <= int_o && !inta_i && hold_q >= {1'b0, lag_i};
            eoi_i <= fire;
            cnt_q <= cnt_q == 3'h0 ? {lag_i, 1'b0} : cnt_q - 3'h1;
            open_q <= open_q + 4'(vector_valid_o) - 4'(fire);
        end
    end
endmodule // ipm_core_model
`default_nettype wire

// >>> verif/interrupt_priority_map_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ipm_checker (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic scan_code_i,
    input wire logic [7:0] mask_i,
    input wire logic inta_i,
    input wire logic eoi_i,
    input wire logic int_o,
    input wire logic [7:0] vector_o,
    input wire logic vector_valid_o,
    input wire logic nmi_o,
    input wire logic [7:0] in_service_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // Spurious code is left out, it sets no service bit
    sequence s_ack; vector_valid_o && vector_o != 8'h0f; endsequence
    sequence s_scan; !scan_code_i ##1 scan_code_i; endsequence
    property p_vld; inta_i |=> vector_valid_o; endproperty
    property p_src; vector_valid_o |-> $past(inta_i); endproperty
    property p_code; vector_valid_o |-> vector_o[7:3] == 5'h01; endproperty
    property p_drop; int_o && inta_i |=> !int_o; endproperty
    property p_msk; (mask_i == 8'hff) [*2] |-> !int_o; endproperty
    property p_isr; s_ack |-> in_service_o[vector_o[2:0]]; endproperty
    property p_nest; s_ack |-> (in_service_o & ~(8'hff << vector_o[2:0])) == 8'h00; endproperty
    property p_eoi; eoi_i && !inta_i && in_service_o != 8'h00
        |=> $countones(in_service_o) == $countones($past(in_service_o)) - 1; endproperty
    property p_nmi; s_scan |-> ##[2:6] nmi_o; endproperty
    property p_nmi1; nmi_o |=> !nmi_o; endproperty
    a_vld: assert property (p_vld) else $error("no vector");
    a_src: assert property (p_src) else $error("stray vector");
    a_code: assert property (p_code) else $error("bad code");
    a_drop: assert property (p_drop) else $error("int held");
    a_msk: assert property (p_msk) else $error("masked int");
    a_isr: assert property (p_isr) else $error("no service bit");
    a_nest: assert property (p_nest) else $error("priority broken");
    a_eoi: assert property (p_eoi) else $error("eoi wrong");
    a_nmi: assert property (p_nmi) else $error("no nmi");
    a_nmi1: assert property (p_nmi1) else $error("long nmi");
endmodule // ipm_checker
bind interrupt_priority_map ipm_checker chk_u (.clock_i, .rst_n_i, .scan_code_i, .mask_i,
    .inta_i, .eoi_i, .int_o, .vector_o, .vector_valid_o, .nmi_o, .in_service_o);
`default_nettype wire

// >>> verif/interrupt_priority_map_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module interrupt_priority_map_tb_top;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] lvl_q = 8'h00; // One request line per level
    logic scan_code_i = 1'b0;
    logic [7:0] mask_i = 8'hff;
    logic [1:0] lag_i = 2'h3;
    logic inta_i, eoi_i, int_o, vector_valid_o, nmi_o;
    logic [7:0] vector_o, in_service_o;
    integer seed = 32685;
    integer miscompares = 0;
    integer n_checks = 0;
    integer cyc = 0;
    integer n_vec = 0;
    integer n_scan = 1;
    integer n_nmi = 0;
    always #5 clock_i = ~clock_i;
    interrupt_priority_map dut_u (.clock_i, .rst_n_i, .timer0_out_i(lvl_q[0]),
        .serial_irq_i(lvl_q[3]), .modem_irq_i(lvl_q[4]), .retrace_irq_i(lvl_q[5]),
        .diskette_irq_i(lvl_q[6]), .chan_irq_i({lvl_q[7], lvl_q[2:1]}), .scan_code_i,
        .mask_i, .inta_i, .eoi_i, .int_o, .vector_o, .vector_valid_o, .nmi_o, .in_service_o);
    ipm_core_model core_u (.clock_i, .rst_n_i, .int_o, .vector_valid_o, .lag_i, .inta_i, .eoi_i);
    // Level 0 held masked first, so it is served last
    function automatic logic [7:0] exp_vec(input integer k);
        exp_vec = 8'h08 + 8'((k + 1) % 8);
    endfunction
    task fail(input string m);
        $display("[FAIL] %0t %s", $time, m);
        miscompares++;
    endtask
    task report_and_stop;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Ack order monitor and hang guard
    always @(posedge clock_i) begin
        cyc++;
        n_nmi <= n_nmi + nmi_o;
        if (vector_valid_o === 1'b1 && n_vec < 8) begin
            n_checks++;
            if (vector_o !== exp_vec(n_vec)) fail("ack order");
            n_vec++;
        end
        if (cyc > 20000) begin
            fail("timeout");
            report_and_stop();
        end
    end
    initial begin
        logic s;
        logic got;
        logic [7:0] want;
        repeat (10) @(posedge clock_i);
        rst_n_i <= 1'b1;
        @(posedge clock_i);
        #1;
        n_checks++;
        if ({int_o, vector_valid_o, nmi_o, vector_o, in_service_o} !== 19'h0) fail("reset");
        // All levels and a scan code raised while everything is masked
        @(posedge clock_i);
        lvl_q <= 8'hff;
        scan_code_i <= 1'b1;
        repeat (10) @(posedge clock_i);
        n_checks++;
        if (int_o !== 1'b0) fail("masked request");
        mask_i <= 8'h01;
        for (int i = 0; i < 400 && n_vec < 7; i++) @(posedge clock_i);
        mask_i <= 8'h00;
        for (int i = 0; i < 400 && n_vec < 8; i++) @(posedge clock_i);
        n_checks++;
        if (n_vec !== 8) fail("missing acks");
        // One source at a time: each pin must land on its own level and code
        lvl_q <= 8'h00;
        repeat (30) @(posedge clock_i);
        for (int k = 0; k < 8; k++) begin
            lvl_q <= 8'h01 << k;
            want = 8'h08 + 8'(k);
            got = 1'b0;
            for (int t = 0; t < 40 && !got; t++) begin
                @(posedge clock_i);
                if (vector_valid_o === 1'b1) got = 1'b1;
            end
            n_checks++;
            if (!got || vector_o !== want) fail("wiring");
            lvl_q <= 8'h00;
            repeat (20) @(posedge clock_i);
        end
        // Random traffic; 4-cycle holds keep pulses wide enough to be seen
        repeat (500) begin
            repeat (4) @(posedge clock_i);
            s = 1'($random(seed));
            if (s && !scan_code_i) n_scan++;
            scan_code_i <= s;
            lvl_q <= 8'($random(seed));
            mask_i <= 8'($random(seed));
            lag_i <= 2'($random(seed));
        end
        repeat (4) @(posedge clock_i);
        {lvl_q, scan_code_i} <= 9'h000;
        repeat (20) @(posedge clock_i);
        n_checks++;
        if (n_nmi !== n_scan) fail("nmi count");
        report_and_stop();
    end
endmodule // interrupt_priority_map_tb_top
`default_nettype wire
